// ==== src/tjg_bit_timer.sv ====
`timescale 1ns/1ps

`include "tjg_defs.svh"

// ****************************************************************
// Bit-time tick generator
// ****************************************************************
module tjg_bit_timer
    import tjg_pkg::*;
#(
    parameter int unsigned CLKS_PER_BIT_LOW  = `TJG_CLKS_PER_BIT(`TJG_BIT_NS_LOW),
    parameter int unsigned CLKS_PER_BIT_HIGH = `TJG_CLKS_PER_BIT(`TJG_BIT_NS_HIGH)
) (
    input  wire logic clk,
    input  wire logic rst_b,
    tjg_tick_if.gen   tk
);

    localparam tjg_div_t LAST_LOW  = tjg_div_t'(CLKS_PER_BIT_LOW - 1);
    localparam tjg_div_t LAST_HIGH = tjg_div_t'(CLKS_PER_BIT_HIGH - 1);

    tjg_div_t div_q;
    tjg_div_t last;
    logic     tick_q;

    // Divider end point follows the selected data rate
    assign last    = tk.rate_high ? LAST_HIGH : LAST_LOW;
    assign tk.tick = tick_q;

    // Divider, realigned to the start of each transmission begun while armed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (tk.restart) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q >= last) begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + tjg_div_t'(1);
            tick_q <= 1'b0;
        end
    end

endmodule // tjg_bit_timer

// ==== src/tjg_defs.svh ====
// Notes on behaviour
// [R1] Guard watches transmit enable itself and cuts the medium path without any command.
// [R2] A frame may transmit continuously for a fixed window of 10 000 bit times.
// [R3] Past the window, transmit output to the medium is blocked until release.
// [R4] While jabbering, transmit data is not echoed onto the receive line.
// [R5] At 31.25 kbit/s the inhibit releases itself after 3 s.
// [R6] At 1 Mbit/s or more the inhibit releases after 500 000 bit times.
// [R7] The window count restarts from zero whenever transmit activity stops.
`ifndef TJG_DEFS_SVH
`define TJG_DEFS_SVH

// ****************************************************************
// Clock and bit timing
// ****************************************************************
`define TJG_CLK_PERIOD_PS      20000
`define TJG_BIT_NS_LOW         32000
`define TJG_BIT_NS_HIGH        1000
`define TJG_CLKS_PER_BIT(ns)   (((ns) * 1000) / `TJG_CLK_PERIOD_PS)
`define TJG_DIV_W              11

// ****************************************************************
// Jabber window and hold-off
// ****************************************************************
`define TJG_WINDOW_BITS        10000
`define TJG_HOLDOFF_LOW_MS     3000
`define TJG_HOLDOFF_LOW_BITS   ((64'd1000000 * `TJG_HOLDOFF_LOW_MS) / `TJG_BIT_NS_LOW)
`define TJG_HOLDOFF_HIGH_BITS  500000
`define TJG_CNT_W              20

// ****************************************************************
// Line levels
// ****************************************************************
`define TJG_RX_IDLE            1'b0
`define TJG_TX_IDLE            1'b0

`endif

// ==== src/tjg_pkg.sv ====
`include "tjg_defs.svh"

package tjg_pkg;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic {
        TJG_ARMED,
        TJG_INHIBIT
    } tjg_state_t;

    typedef logic [`TJG_CNT_W-1:0] tjg_count_t;
    typedef logic [`TJG_DIV_W-1:0] tjg_div_t;

endpackage

// ==== src/tjg_tick_if.sv ====
`timescale 1ns/1ps

// Bit-time tick link between the guard and its divider
interface tjg_tick_if;
    logic rate_high;
    logic restart;
    logic tick;

    modport ctl (output rate_high, output restart, input tick);
    modport gen (input rate_high, input restart, output tick);
endinterface // tjg_tick_if

// ==== src/tjg_transmit_jabber_guard.sv ====
`timescale 1ns/1ps

`include "tjg_defs.svh"

// ****************************************************************
// Transmit jabber guard
// ****************************************************************
// Sits between the medium dependent sublayer and the line driver.
// Times each continuous transmission in bit times and, when a frame
// runs past the window, cuts the line driver and mutes the echo on
// the receive line. A hold-off timer then re-arms the guard.
module tjg_transmit_jabber_guard
    import tjg_pkg::*;
#(
    parameter int unsigned WINDOW_BITS       = `TJG_WINDOW_BITS,
    parameter int unsigned HOLDOFF_LOW_BITS  = int'(`TJG_HOLDOFF_LOW_BITS),
    parameter int unsigned HOLDOFF_HIGH_BITS = `TJG_HOLDOFF_HIGH_BITS,
    parameter int unsigned CLKS_PER_BIT_LOW  = `TJG_CLKS_PER_BIT(`TJG_BIT_NS_LOW),
    parameter int unsigned CLKS_PER_BIT_HIGH = `TJG_CLKS_PER_BIT(`TJG_BIT_NS_HIGH)
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic tx_enable,
    input  wire logic tx_data,
    input  wire logic rate_high,
    input  wire logic medium_rx_data,
    output logic      medium_tx_enable_q,
    output logic      medium_tx_data_q,
    output logic      receive_line_to_sublayer_q,
    output logic      jabber_q
);

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam tjg_count_t WINDOW_LAST       = tjg_count_t'(WINDOW_BITS - 1);
    localparam tjg_count_t HOLDOFF_LOW_LAST  = tjg_count_t'(HOLDOFF_LOW_BITS - 1);
    localparam tjg_count_t HOLDOFF_HIGH_LAST = tjg_count_t'(HOLDOFF_HIGH_BITS - 1);
    localparam tjg_count_t COUNT_ONE         = tjg_count_t'(1);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    tjg_tick_if tk ();

    tjg_state_t state_q;
    tjg_state_t state_d;
    tjg_count_t win_cnt_q;
    tjg_count_t hold_cnt_q;
    tjg_count_t hold_last;
    logic       tx_active_q;
    logic       tx_start;
    logic       window_hit;
    logic       hold_done;
    logic       inhibit_d;

    // Saturating increment shared by both timers
    function automatic tjg_count_t tjg_bump(input tjg_count_t value);
        if (value == '1) begin
            tjg_bump = value;
        end else begin
            tjg_bump = value + COUNT_ONE;
        end
    endfunction

    // ****************************************************************
    // Bit-time tick
    // ****************************************************************
    // Divider restarts with each armed frame so the first bit is a full bit;
    // frames started while inhibited must not stall the hold-off ticks
    assign tk.rate_high = rate_high;
    assign tk.restart   = tx_start && (state_q == TJG_ARMED);   // [R5] [R6]

    tjg_bit_timer #(
        .CLKS_PER_BIT_LOW  (CLKS_PER_BIT_LOW),
        .CLKS_PER_BIT_HIGH (CLKS_PER_BIT_HIGH)
    ) u_bit_timer (
        .clk   (clk),
        .rst_b (rst_b),
        .tk    (tk.gen)
    );

    // ****************************************************************
    // Transmit activity detection
    // ****************************************************************
    // Own observation of the transmit enable, no external command
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_active_q <= 1'b0;
        end else begin
            tx_active_q <= tx_enable;                          // [R1]
        end
    end

    assign tx_start = tx_enable & ~tx_active_q;

    // ****************************************************************
    // Jabber window timer
    // ****************************************************************
    // Counts whole bit times of continuous transmission while armed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            win_cnt_q <= '0;
        end else if (state_q != TJG_ARMED || !tx_enable) begin
            win_cnt_q <= '0;                                   // [R7]
        end else if (tk.tick) begin
            win_cnt_q <= tjg_bump(win_cnt_q);                  // [R2]
        end
    end

    // Window expires on the tick that ends its last bit time
    assign window_hit = (state_q == TJG_ARMED) && tx_enable && tk.tick
                        && (win_cnt_q >= WINDOW_LAST);         // [R2]

    // ****************************************************************
    // Hold-off timer
    // ****************************************************************
    // Hold-off length follows the data rate
    assign hold_last = rate_high ? HOLDOFF_HIGH_LAST           // [R6]
                                 : HOLDOFF_LOW_LAST;           // [R5]

    // Counts bit times spent inhibited, cleared while armed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_cnt_q <= '0;
        end else if (state_q != TJG_INHIBIT) begin
            hold_cnt_q <= '0;
        end else if (tk.tick) begin
            hold_cnt_q <= tjg_bump(hold_cnt_q);
        end
    end

    assign hold_done = (state_q == TJG_INHIBIT) && tk.tick
                       && (hold_cnt_q >= hold_last);           // [R5] [R6]

    // ****************************************************************
    // Guard state machine
    // ****************************************************************
    // Next state of the guard
    always_comb begin
        state_d = state_q;
        case (state_q)
            TJG_ARMED: begin
                if (window_hit) begin
                    state_d = TJG_INHIBIT;                     // [R3]
                end
            end
            TJG_INHIBIT: begin
                if (hold_done) begin
                    state_d = TJG_ARMED;                       // [R5] [R6]
                end
            end
            default: begin
                state_d = TJG_ARMED;
            end
        endcase
    end

    // Guard state register, armed after reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= TJG_ARMED;
        end else begin
            state_q <= state_d;
        end
    end

    assign inhibit_d = (state_d == TJG_INHIBIT);

    // ****************************************************************
    // Medium transmit path
    // ****************************************************************
    // Driver enabled only while armed; data forced idle when cut
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            medium_tx_enable_q <= 1'b0;
            medium_tx_data_q   <= `TJG_TX_IDLE;
        end else if (inhibit_d) begin
            medium_tx_enable_q <= 1'b0;                        // [R3]
            medium_tx_data_q   <= `TJG_TX_IDLE;                // [R3]
        end else begin
            medium_tx_enable_q <= tx_enable;                   // [R1]
            medium_tx_data_q   <= tx_enable ? tx_data : `TJG_TX_IDLE;
        end
    end

    // ****************************************************************
    // Receive line toward the sublayer
    // ****************************************************************
    // Echo of own transmission, muted while jabbering
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            receive_line_to_sublayer_q <= `TJG_RX_IDLE;
        end else if (!tx_enable) begin
            receive_line_to_sublayer_q <= medium_rx_data;      // Plain reception
        end else if (inhibit_d) begin
            receive_line_to_sublayer_q <= `TJG_RX_IDLE;        // [R4]
        end else begin
            receive_line_to_sublayer_q <= tx_data;             // Echo
        end
    end

    // ****************************************************************
    // Jabber status
    // ****************************************************************
    // Level that mirrors the inhibit, aligned with the path outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            jabber_q <= 1'b0;
        end else begin
            jabber_q <= inhibit_d;                             // [R3]
        end
    end

endmodule // tjg_transmit_jabber_guard

// ==== verification/tjg_guard_properties.sv ====
`timescale 1ns/1ps
// ********
// Guard port checker
// ********
module tjg_guard_properties #(
    parameter int unsigned WINDOW_BITS       = 4,
    parameter int unsigned HOLDOFF_LOW_BITS  = 5,
    parameter int unsigned HOLDOFF_HIGH_BITS = 6,
    parameter int unsigned CLKS_PER_BIT_LOW  = 3,
    parameter int unsigned CLKS_PER_BIT_HIGH = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tx_enable,
    input wire logic tx_data,
    input wire logic rate_high,
    input wire logic medium_rx_data,
    input wire logic medium_tx_enable_q,
    input wire logic medium_tx_data_q,
    input wire logic receive_line_to_sublayer_q,
    input wire logic jabber_q
);
    int unsigned run_q;
    int unsigned hold_q;
    int unsigned bit_c;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Clocks of armed transmission and of inhibit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q  <= 0;
            hold_q <= 0;
        end else begin
            run_q  <= (tx_enable && !jabber_q) ? run_q + 1 : 0;
            hold_q <= jabber_q ? hold_q + 1 : 0;
        end
    end
    assign bit_c = rate_high ? CLKS_PER_BIT_HIGH : CLKS_PER_BIT_LOW;
    AST_TX_CUT: assert property (jabber_q |-> !medium_tx_enable_q)
        else $error("driver on while inhibited");
    AST_DATA_IDLE: assert property (!medium_tx_enable_q |-> !medium_tx_data_q)
        else $error("data while driver off");
    AST_TX_FOLLOW: assert property ($past(rst_b) && !jabber_q |->
        medium_tx_enable_q == $past(tx_enable) && (!$past(tx_enable)
        || medium_tx_data_q == $past(tx_data))) else $error("driver not following");
    AST_ECHO_MUTE: assert property ($past(tx_enable) && jabber_q |->
        !receive_line_to_sublayer_q) else $error("echo while inhibited");
    AST_ECHO_ARMED: assert property ($past(rst_b) && $past(tx_enable) && !jabber_q |->
        receive_line_to_sublayer_q == $past(tx_data)) else $error("echo missing");
    AST_RX_PASS: assert property ($past(rst_b) && !$past(tx_enable) |->
        receive_line_to_sublayer_q == $past(medium_rx_data)) else $error("rx not passed");
    AST_WINDOW_LEN: assert property ($rose(jabber_q) |->
        run_q inside {[(WINDOW_BITS - 1) * bit_c + 1 : WINDOW_BITS * bit_c + 2]})
        else $error("window length wrong");
    AST_HOLD_LOW: assert property ($fell(jabber_q) && !rate_high |-> hold_q inside
        {[(HOLDOFF_LOW_BITS - 1) * CLKS_PER_BIT_LOW - 1 : (HOLDOFF_LOW_BITS + 1) * CLKS_PER_BIT_LOW]})
        else $error("low rate hold-off wrong");
    AST_HOLD_HIGH: assert property ($fell(jabber_q) && rate_high |-> hold_q inside
        {[(HOLDOFF_HIGH_BITS - 1) * CLKS_PER_BIT_HIGH - 1 : (HOLDOFF_HIGH_BITS + 1) * CLKS_PER_BIT_HIGH]})
        else $error("high rate hold-off wrong");
endmodule // tjg_guard_properties

bind tjg_transmit_jabber_guard tjg_guard_properties #(
    .WINDOW_BITS(WINDOW_BITS), .HOLDOFF_LOW_BITS(HOLDOFF_LOW_BITS),
    .HOLDOFF_HIGH_BITS(HOLDOFF_HIGH_BITS), .CLKS_PER_BIT_LOW(CLKS_PER_BIT_LOW),
    .CLKS_PER_BIT_HIGH(CLKS_PER_BIT_HIGH)
) u_props (
    .clk(clk), .rst_b(rst_b), .tx_enable(tx_enable), .tx_data(tx_data),
    .rate_high(rate_high), .medium_rx_data(medium_rx_data),
    .medium_tx_enable_q(medium_tx_enable_q), .medium_tx_data_q(medium_tx_data_q),
    .receive_line_to_sublayer_q(receive_line_to_sublayer_q), .jabber_q(jabber_q)
);

// ==== verification/tjg_sublayer_model.sv ====
`timescale 1ns/1ps
// ********
// Sublayer transmit model
// ********
module tjg_sublayer_model (
    input  wire logic clk,
    output logic      tx_enable,
    output logic      tx_data
);
    initial begin
        tx_enable = 1'b0;
        tx_data   = 1'b0;
    end
    // One frame of ncyc clocks, levels changed at falling edges
    task automatic frame(input int ncyc);
        repeat (ncyc) begin
            @(negedge clk);
            tx_enable = 1'b1;
            tx_data   = 1'($urandom);
        end
        @(negedge clk);
        tx_enable = 1'b0;
        tx_data   = ~tx_data; // No stale level after release
    endtask
endmodule // tjg_sublayer_model

// ==== verification/tjg_transmit_jabber_guard_tb.sv ====
`timescale 1ns/1ps
// ********
// Jabber guard testbench
// ********
module tjg_transmit_jabber_guard_tb;
    localparam int W = 4, HL = 5, HH = 6, CL = 3, CH = 2;
    typedef struct {logic lvl; int lo; int hi;} tjg_note_t;
    logic clk, tx_enable, tx_data, mtx_en, mtx_dat, rx_line, jabber_q;
    logic rst_b = 1'b0, rate_high = 1'b1, medium_rx_data = 1'b0, jab_prev = 1'b0;
    int err_count = 0, total_checks = 0, cyc = 0;
    tjg_note_t notes[$];

    tjg_transmit_jabber_guard #(
        .WINDOW_BITS(W), .HOLDOFF_LOW_BITS(HL), .HOLDOFF_HIGH_BITS(HH),
        .CLKS_PER_BIT_LOW(CL), .CLKS_PER_BIT_HIGH(CH)
    ) DUT (
        .clk(clk), .rst_b(rst_b), .tx_enable(tx_enable), .tx_data(tx_data),
        .rate_high(rate_high), .medium_rx_data(medium_rx_data),
        .medium_tx_enable_q(mtx_en), .medium_tx_data_q(mtx_dat),
        .receive_line_to_sublayer_q(rx_line), .jabber_q(jabber_q)
    );
    tjg_sublayer_model m (.clk(clk), .tx_enable(tx_enable), .tx_data(tx_data));

    task automatic stop_test();
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Notes the rise, and the release if asked, of a frame starting now
    task automatic expect_jab(input int c, input int h, input bit fall);
        int b;
        b = cyc + 2 + W * c;
        notes.push_back('{1'b1, b + 1 - c, b + 2});
        if (fall)
            notes.push_back('{1'b0, b + (h - 2) * c, b + (h + 1) * c + 3});
    endtask

    // Clock, cycle count and stall guard
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc > 3000) begin
            err_count++;
            stop_test();
        end
    end

    // Random line receiver data, and each inhibit edge against the oldest note
    always @(negedge clk) begin
        tjg_note_t n;
        medium_rx_data <= 1'($urandom);
        if (jabber_q === 1'b1)
            check("driver cut", mtx_en, 1'b0);
        if (jabber_q !== jab_prev) begin
            if (notes.size() == 0)
                check("unexpected edge", 1'b1, 1'b0);
            else begin
                n = notes.pop_front();
                check("edge level", jabber_q, n.lvl);
                check("edge time", cyc >= n.lo && cyc <= n.hi, 1'b1);
            end
            jab_prev = jabber_q;
        end
    end

    // Main sequence
    initial begin
        void'($urandom(27388));
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        // Short frames split by one idle clock never trip the guard
        repeat (2) m.frame((W - 2) * CH + 1);
        // Reset in mid-inhibit releases at once
        @(negedge clk);
        expect_jab(CH, HH, 1'b0);
        m.frame(W * CH + 2);
        @(negedge clk);
        notes.push_back('{1'b0, cyc, cyc + 1});
        rst_b = 1'b0;
        @(negedge clk);
        rst_b = 1'b1;
        // Over-long frame at each rate, then the hold-off
        for (int r = 1; r >= 0; r--) begin
            rate_high = r[0];
            @(negedge clk);
            expect_jab(r ? CH : CL, r ? HH : HL, 1'b1);
            m.frame(W * (r ? CH : CL) + 2);
            repeat ((HL + 2) * CL + 4) @(negedge clk);
        end
        check("pending notes", notes.size(), 0);
        stop_test();
    end
endmodule // tjg_transmit_jabber_guard_tb
